//--- cfgrb_pkg.sv
// constants and carrier types for the configurable registered buffer
// assumes one 100 MHz core clock that stands for the differential clock crossing
// Operation
// - capture inputs on clock rise, drive outputs
// - select pin picks arrangement A or B
// - fanout pin low 22-bit, high 11-bit doubled
// - reset clears register, holds outputs low
// - reset disables receivers, undriven inputs tolerated
// - reset acts without waiting for clock
// - outputs stay low until receivers enabled
// - both chip selects high freeze outputs
// - either chip select low updates outputs
// - reset overrides chip-select gating
// - logic correct up to 450 MHz
// - enable, termination, select outputs never frozen
package cfgrb_pkg;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int DATA_W = 22;
    localparam int HALF_W = 11;
    localparam int CNT_W = 8;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [DATA_W-1:0] DATA_RST = 22'h000000;
    localparam logic [HALF_W-1:0] HALF_RST = 11'h000;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    localparam logic [1:0] SYNC_RST = 2'h0;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int MAX_CLK_MHZ = 450;
    localparam int RX_EN_NS = 20;
    localparam int RX_EN_RAW = (RX_EN_NS * CLK_MHZ + 999) / 1000;
    localparam int RX_EN_CYCLES = (RX_EN_RAW < 1) ? 1 : RX_EN_RAW;
    localparam logic [CNT_W-1:0] RX_EN_LAST = CNT_W'(RX_EN_CYCLES - 1);

    // ----------------------------------------
    // states and carriers
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_RESET = 3'h1,
        ST_WAKE = 3'h2,
        ST_RUN = 3'h4
    } cfgrb_state_t;

    typedef struct packed {
        logic cke;
        logic odt;
        logic cs;
    } cfgrb_ctrl_t;

    typedef struct packed {
        logic [DATA_W-1:0] a;
        logic [HALF_W-1:0] b;
        cfgrb_ctrl_t ctrl_a;
        cfgrb_ctrl_t ctrl_b;
    } cfgrb_out_t;

    localparam cfgrb_ctrl_t CTRL_RST = '{cke: 1'b0, odt: 1'b0, cs: 1'b0};

endpackage : cfgrb_pkg

//--- cfgrb_top.sv
// configurable registered buffer: 22-bit one-copy or 11-bit two-copy register
// assumes the controller drives data on core_clk_i and holds reset low at power-up
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// two-flop synchroniser for one level pin
// ----------------------------------------
module cfgrb_sync2 #(
    parameter logic [1:0] RST_VAL = 2'h0
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic pin_i,
    output logic level_o
);

    logic [1:0] sync_q;

    // only the second stage is read, the first may be metastable
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_q <= RST_VAL;
        end else begin
            sync_q <= {sync_q[0], pin_i};
        end
    end

    assign level_o = sync_q[1];

endmodule : cfgrb_sync2

module cfgrb_top (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic arrangement_select_pin_i,
    input wire logic fanout_select_pin_i,
    input wire logic primary_chip_select_n_i,
    input wire logic secondary_chip_select_n_i,
    input wire logic clock_enable_in_i,
    input wire logic termination_ctrl_in_i,
    input wire logic [cfgrb_pkg::DATA_W-1:0] buffered_inputs_i,
    output var cfgrb_pkg::cfgrb_out_t gated_outputs_o,
    output logic rx_enabled_o
);

    // ----------------------------------------
    // config pin synchronisers
    // ----------------------------------------
    logic [1:0] cfg_pins;
    wire logic [1:0] cfg_levels;
    logic arr_b;
    logic two_copy;

    assign cfg_pins = {fanout_select_pin_i, arrangement_select_pin_i};

    for (genvar gi = 0; gi < 2; gi++) begin : g_cfg_sync
        cfgrb_sync2 #(
            .RST_VAL(cfgrb_pkg::SYNC_RST)
        ) cfgrb_sync2_inst (
            .core_clk_i(core_clk_i),
            .rstn_i(rstn_i),
            .pin_i(cfg_pins[gi]),
            .level_o(cfg_levels[gi])
        );
    end

    // a mode change reaches the datapath two edges after the pin moves
    assign arr_b = cfg_levels[0];
    assign two_copy = cfg_levels[1];

    // ----------------------------------------
    // receiver wake-up sequence
    // ----------------------------------------
    cfgrb_pkg::cfgrb_state_t state_q;
    logic [cfgrb_pkg::CNT_W-1:0] wake_cnt_q;
    logic rx_en_q;

    // receivers stay off for a fixed settling time after reset is released
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= cfgrb_pkg::ST_RESET;
            wake_cnt_q <= cfgrb_pkg::CNT_RST;
            rx_en_q <= 1'b0;
        end else begin
            unique case (state_q)
                cfgrb_pkg::ST_RESET: begin
                    state_q <= cfgrb_pkg::ST_WAKE;
                    wake_cnt_q <= cfgrb_pkg::CNT_RST;
                end
                cfgrb_pkg::ST_WAKE: begin
                    if (wake_cnt_q == cfgrb_pkg::RX_EN_LAST) begin
                        state_q <= cfgrb_pkg::ST_RUN;
                        rx_en_q <= 1'b1;
                    end else begin
                        wake_cnt_q <= wake_cnt_q + 8'h01;
                    end
                end
                cfgrb_pkg::ST_RUN: begin
                    rx_en_q <= 1'b1;
                end
                default: begin
                    state_q <= cfgrb_pkg::ST_RESET;
                    rx_en_q <= 1'b0;
                end
            endcase
        end
    end

    logic rx_en;
    assign rx_en = rx_en_q;

    // ----------------------------------------
    // input receivers
    // ----------------------------------------
    logic [cfgrb_pkg::DATA_W-1:0] rx_data;
    logic rx_cke;
    logic rx_odt;
    logic rx_dcs_n;
    logic rx_csr_n;

    // disabled receivers read low, so floating inputs never reach the register
    assign rx_data = rx_en ? buffered_inputs_i : cfgrb_pkg::DATA_RST;
    assign rx_cke = rx_en & clock_enable_in_i;
    assign rx_odt = rx_en & termination_ctrl_in_i;
    assign rx_dcs_n = rx_en & primary_chip_select_n_i;
    assign rx_csr_n = rx_en & secondary_chip_select_n_i;

    // ----------------------------------------
    // output register
    // ----------------------------------------
    logic freeze;
    logic [cfgrb_pkg::HALF_W-1:0] half_sel;
    cfgrb_pkg::cfgrb_ctrl_t ctrl_new;
    logic [cfgrb_pkg::DATA_W-1:0] a_q;
    logic [cfgrb_pkg::HALF_W-1:0] b_q;
    cfgrb_pkg::cfgrb_ctrl_t ctrl_a_q;
    cfgrb_pkg::cfgrb_ctrl_t ctrl_b_q;

    assign freeze = rx_dcs_n & rx_csr_n;
    assign half_sel = arr_b ? rx_data[cfgrb_pkg::DATA_W-1:cfgrb_pkg::HALF_W]
                            : rx_data[cfgrb_pkg::HALF_W-1:0];
    assign ctrl_new = '{cke: rx_cke, odt: rx_odt, cs: rx_dcs_n};

    // wide data copy: reset clears it without a clock edge and beats the freeze
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            a_q <= cfgrb_pkg::DATA_RST;
        end else if (!freeze) begin
            if (two_copy) begin
                a_q <= {{(cfgrb_pkg::DATA_W-cfgrb_pkg::HALF_W){1'b0}}, half_sel};
            end else begin
                a_q <= rx_data;
            end
        end
    end

    // second data copy, only carries data in two-copy mode
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            b_q <= cfgrb_pkg::HALF_RST;
        end else if (!freeze) begin
            if (two_copy) begin
                b_q <= half_sel;
            end else begin
                b_q <= cfgrb_pkg::HALF_RST;
            end
        end
    end

    // control bits follow every edge, the chip selects never hold them
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_a_q <= cfgrb_pkg::CTRL_RST;
        end else begin
            ctrl_a_q <= ctrl_new;
        end
    end

    // second control copy mirrors the first in two-copy mode
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_b_q <= cfgrb_pkg::CTRL_RST;
        end else if (two_copy) begin
            ctrl_b_q <= ctrl_new;
        end else begin
            ctrl_b_q <= cfgrb_pkg::CTRL_RST;
        end
    end

    assign gated_outputs_o = '{a: a_q, b: b_q, ctrl_a: ctrl_a_q, ctrl_b: ctrl_b_q};
    assign rx_enabled_o = rx_en_q;

endmodule : cfgrb_top
`default_nettype wire

//--- cfgrb_properties.sv
// port checker for cfgrb_top
// assumes config pins change only while reset is low
`timescale 1ns/1ps
`default_nettype none
module cfgrb_properties (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic arrangement_select_pin_i,
    input wire logic fanout_select_pin_i,
    input wire logic primary_chip_select_n_i,
    input wire logic secondary_chip_select_n_i,
    input wire logic clock_enable_in_i,
    input wire logic termination_ctrl_in_i,
    input wire logic [cfgrb_pkg::DATA_W-1:0] buffered_inputs_i,
    input wire cfgrb_pkg::cfgrb_out_t gated_outputs_o,
    input wire logic rx_enabled_o
);
    wire cfgrb_pkg::cfgrb_out_t q = gated_outputs_o;
    wire logic [21:0] d = buffered_inputs_i;
    wire logic hold = primary_chip_select_n_i & secondary_chip_select_n_i;
    wire logic upd = rx_enabled_o & ~hold;
    wire logic two = fanout_select_pin_i;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    a_reset_clears: assert property ($rose(rstn_i) |-> q == '0)
        else $error("outputs not low after reset");
    a_wake_delay: assert property ($rose(rstn_i) |-> !rx_enabled_o [*3] ##1 rx_enabled_o)
        else $error("receiver enable timing wrong");
    a_low_asleep: assert property (!rx_enabled_o |-> q == '0)
        else $error("output moved before enable");
    a_one_copy: assert property (upd && !two |=> q.a == $past(d) && q.b == '0)
        else $error("single copy capture wrong");
    a_pick_half: assert property (upd && two |=>
        q.b == $past(arrangement_select_pin_i ? d[21:11] : d[10:0]))
        else $error("wrong half captured");
    a_copies_equal: assert property (two |-> q.a == {11'h000, q.b} && q.ctrl_a == q.ctrl_b)
        else $error("copies differ");
    a_freeze_hold: assert property (rx_enabled_o && hold |=> $stable(q.a) && $stable(q.b))
        else $error("frozen outputs changed");
    a_ctrl_free: assert property (rx_enabled_o |=> q.ctrl_a ==
        $past({clock_enable_in_i, termination_ctrl_in_i, primary_chip_select_n_i}))
        else $error("control outputs wrong");
endmodule : cfgrb_properties
bind cfgrb_top cfgrb_properties cfgrb_properties_inst (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .arrangement_select_pin_i(arrangement_select_pin_i),
    .fanout_select_pin_i(fanout_select_pin_i),
    .primary_chip_select_n_i(primary_chip_select_n_i),
    .secondary_chip_select_n_i(secondary_chip_select_n_i),
    .clock_enable_in_i(clock_enable_in_i),
    .termination_ctrl_in_i(termination_ctrl_in_i),
    .buffered_inputs_i(buffered_inputs_i),
    .gated_outputs_o(gated_outputs_o),
    .rx_enabled_o(rx_enabled_o)
);
`default_nettype wire

//--- cfgrb_ctrl_model.sv
// controller model: drives one word per call
// assumes the bench releases reset before calling send
`timescale 1ns/1ps
`default_nettype none
module cfgrb_ctrl_model (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    output logic [cfgrb_pkg::DATA_W-1:0] d_o,
    output logic [3:0] c_o
);
    // inputs low from power-up and across every reset
    initial begin
        d_o = '0;
        c_o = '0;
    end
    always @(negedge rstn_i) begin
        d_o <= '0;
        c_o <= '0;
    end
    // c is cke, odt, primary, secondary; secondary low disables gating
    task automatic send(input logic [21:0] d, input logic [3:0] c);
        @(posedge core_clk_i);
        d_o <= d;
        c_o <= c;
        @(posedge core_clk_i);
        #1;
    endtask : send
endmodule : cfgrb_ctrl_model
`default_nettype wire

//--- cfgrb_top_tb.sv
// bench: one copy, freeze, async reset, both two-copy arrangements
// assumes the controller model drives the data side
`timescale 1ns/1ps
`default_nettype none
module cfgrb_top_tb;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic arrangement_select_pin_i = 1'b0;
    logic fanout_select_pin_i = 1'b0;
    wire logic [cfgrb_pkg::DATA_W-1:0] buffered_inputs_i;
    wire logic [3:0] c;
    cfgrb_pkg::cfgrb_out_t gated_outputs_o;
    cfgrb_pkg::cfgrb_out_t e;
    logic rx_enabled_o;
    int n_mismatch = 0;
    int cmp_count = 0;
    cfgrb_top cfgrb_top_inst (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .arrangement_select_pin_i(arrangement_select_pin_i),
        .fanout_select_pin_i(fanout_select_pin_i),
        .primary_chip_select_n_i(c[1]),
        .secondary_chip_select_n_i(c[0]),
        .clock_enable_in_i(c[3]),
        .termination_ctrl_in_i(c[2]),
        .buffered_inputs_i(buffered_inputs_i),
        .gated_outputs_o(gated_outputs_o),
        .rx_enabled_o(rx_enabled_o)
    );
    cfgrb_ctrl_model cfgrb_ctrl_model_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .d_o(buffered_inputs_i), .c_o(c));
    initial forever #5 core_clk_i = ~core_clk_i;
    task automatic chk(input string n, input logic [63:0] s, x);
        cmp_count++;
        if (s !== x) begin
            n_mismatch++;
            $display("mismatch %s exp %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    task automatic rst(input logic f, a);
        int k;
        @(posedge core_clk_i);
        rstn_i <= 1'b0;
        fanout_select_pin_i <= f;
        arrangement_select_pin_i <= a;
        repeat (8) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        e = '0;
        for (k = 0; k < 20 && rx_enabled_o !== 1'b1; k++) begin
            @(posedge core_clk_i);
            #1;
            chk("asleep", gated_outputs_o, e);
        end
        chk("wake", k, cfgrb_pkg::RX_EN_CYCLES + 1);
        if (rx_enabled_o !== 1'b1) begin
            n_mismatch++;
            results();
        end
    endtask : rst
    task automatic put(input logic [21:0] d, input logic [3:0] v);
        e.ctrl_a = v[3:1];
        if (v[1:0] != 2'h3) begin
            e.b = fanout_select_pin_i ? (arrangement_select_pin_i ? d[21:11] : d[10:0]) : 11'h000;
            e.a = fanout_select_pin_i ? {11'h000, e.b} : d;
        end
        e.ctrl_b = fanout_select_pin_i ? e.ctrl_a : cfgrb_pkg::CTRL_RST;
        cfgrb_ctrl_model_inst.send(d, v);
        chk("outputs", gated_outputs_o, e);
    endtask : put
    initial begin
        rst(1'b0, 1'b0);
        put(22'h2A5A5A, 4'hA);
        put(22'h15A5A5, 4'h4);
        put(22'h3FFFFF, 4'hB);
        put(22'h000001, 4'h1);
        put(22'h3C0F0F, 4'h3);
        @(posedge core_clk_i);
        rstn_i <= 1'b0;
        #1;
        chk("async", gated_outputs_o, '0);
        for (int m = 0; m < 2; m++) begin
            rst(1'b1, m[0]);
            put(22'h2D2D2D, 4'hE);
            put(22'h12ABCD, 4'h3);
            put(22'h3FF800, 4'h5);
        end
        results();
    end
endmodule : cfgrb_top_tb
`default_nettype wire
